//--- rtl/mtsp_pkg.sv
// shared constants and types of the multimode target serial port
// assumes one system clock; the target-facing clock is derived from it
package mtsp_pkg;

   // system clock and target clock periods
   localparam int CLK_PERIOD_NS = 40;
   localparam int LINK_PERIOD_NS = 320;
   // half a target clock period in system cycles, rounded up so the low and high times are never short
   localparam int HALF_CYCLES = (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

   // pin levels
   localparam logic PIN_HIGH = 1'b1;
   localparam logic PIN_LOW = 1'b0;
   localparam logic PSEUDO_GROUND_OUT_LEVEL = 1'b0;

   // target protocol selected for one operation
   typedef enum logic [1:0] {MODE_SCAN, MODE_SPI, MODE_SERIAL} mtsp_mode_t;

   // operation sequencer
   typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_PARK} mtsp_state_t;

endpackage : mtsp_pkg

//--- rtl/mtsp_port.sv
// multimode target serial port: scan chain, serial flash and slave-serial configuration master
// assumes the user side runs on clk_sys; the return pin is asynchronous and is synchronised here
module mtsp_port
   import mtsp_pkg::*;
#(
   parameter int unsigned HALF = mtsp_pkg::HALF_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire mtsp_pkg::mtsp_mode_t modeSel,
   input wire logic haltEnable,
   input wire logic haltVendor,
   input wire logic opRequest,
   input wire logic bitValid,
   input wire logic bitData,
   input wire logic bitSel,
   output logic bitAck,
   output logic rxValid,
   output logic rxData,
   output logic busy,
   input wire logic sharedClockPinIn,
   output logic sharedClockPinOut,
   output logic sharedClockPinOe,
   input wire logic dataPinIn,
   output logic dataPinOut,
   output logic dataPinOe,
   input wire logic sharedSelectPinIn,
   output logic sharedSelectPinOut,
   output logic sharedSelectPinOe,
   input wire logic returnPinIn,
   output logic returnPinOut,
   output logic returnPinOe,
   input wire logic holdPinIn,
   output logic holdPinOut,
   output logic holdPinOe,
   output logic pseudoGroundOut,
   output logic pseudoGroundOe
);
   import mtsp_pkg::*;

   typedef struct packed {
      mtsp_state_t state;
      mtsp_mode_t mode;
      logic clk;
      logic clkOe;
      logic data;
      logic dataOe;
      logic sel;
      logic selOe;
      logic hold;
      logic holdOe;
      logic pgndOe;
      logic haveBit;
      logic ack;
      logic rxValid;
      logic rxData;
      logic busy;
      logic retMeta;
      logic retSync;
   } mtsp_regs_t;

   localparam mtsp_regs_t REGS_RESET = '0;

   mtsp_regs_t r_reg;
   mtsp_regs_t r_next;
   logic tick;
   logic returnSampleStrobe;

   // the return pin needs a half period of at least two system cycles for the synchroniser
   if (HALF < 2) begin : gen_bad_half
      $error("mtsp_port: HALF must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // target clock phase: restarted on every operation so the first low time is full
   mtsp_tick_div #(
      .DIV(HALF)
   ) u_div (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clear(r_reg.state == ST_IDLE),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: idle, shift bits one clock each, park outputs high, release
   always_comb begin
      r_next = r_reg;
      returnSampleStrobe = 1'b0;
      r_next.ack = 1'b0;
      r_next.rxValid = 1'b0;
      r_next.retMeta = returnPinIn;
      r_next.retSync = r_reg.retMeta;
      unique case (r_reg.state)
         ST_IDLE: begin
            // mode is latched only here, while every driver is off
            if (opRequest && (modeSel inside {MODE_SCAN, MODE_SPI, MODE_SERIAL})) begin
               r_next.state = ST_ACTIVE;
               r_next.mode = modeSel;
               r_next.clk = PIN_LOW;
               r_next.clkOe = 1'b1;
               r_next.data = PIN_HIGH;
               r_next.dataOe = 1'b1;
               r_next.selOe = 1'b1;
               // chip select falls for the whole access; tms and reconfig request rest high
               r_next.sel = (modeSel == MODE_SPI) ? PIN_LOW : PIN_HIGH;
               r_next.pgndOe = 1'b1;
               // hold only in scan mode and only when the host asks for it
               r_next.holdOe = (modeSel == MODE_SCAN) && haltEnable;
               r_next.hold = haltVendor ? PIN_LOW : PIN_HIGH;
               r_next.haveBit = 1'b0;
            end
         end
         ST_ACTIVE: begin
            if (tick) begin
               if (r_reg.clk) begin
                  // last system cycle of the high phase: target output has settled
                  returnSampleStrobe = 1'b1;
                  r_next.rxValid = 1'b1;
                  r_next.rxData = r_reg.retSync;
                  r_next.clk = PIN_LOW;
                  r_next.haveBit = 1'b0;
               end else if (r_reg.haveBit) begin
                  r_next.clk = PIN_HIGH;
               end else if (!bitValid && !opRequest) begin
                  // end of operation: drive everything high before letting go
                  r_next.state = ST_PARK;
                  r_next.clk = PIN_HIGH;
                  r_next.data = PIN_HIGH;
                  r_next.sel = PIN_HIGH;
                  r_next.hold = PIN_HIGH;
                  r_next.pgndOe = 1'b0;
               end
               // next bit is loaded on the falling edge or during a stalled low phase
               if (bitValid && (r_reg.clk || !r_reg.haveBit)) begin
                  r_next.haveBit = 1'b1;
                  r_next.ack = 1'b1;
                  r_next.data = bitData;
                  // scan: tms; serial: reconfig_out; flash keeps chip select low
                  if (r_reg.mode != MODE_SPI) begin
                     r_next.sel = bitSel;
                  end
                  r_next.state = ST_ACTIVE;
                  r_next.pgndOe = 1'b1;
               end
            end
         end
         ST_PARK: begin
            if (tick) begin
               r_next.state = ST_IDLE;
               r_next.clkOe = 1'b0;
               r_next.dataOe = 1'b0;
               r_next.selOe = 1'b0;
               r_next.holdOe = 1'b0;
            end
         end
      endcase
      // busy is kept as its own flip-flop so the output carries no decode glitch
      r_next.busy = (r_next.state != ST_IDLE);
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         r_reg <= REGS_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; the return pin is never driven in any mode
   assign bitAck = r_reg.ack;
   assign rxValid = r_reg.rxValid;
   assign rxData = r_reg.rxData;
   assign busy = r_reg.busy;
   assign sharedClockPinOut = r_reg.clk;
   assign sharedClockPinOe = r_reg.clkOe;
   assign dataPinOut = r_reg.data;
   assign dataPinOe = r_reg.dataOe;
   assign sharedSelectPinOut = r_reg.sel;
   assign sharedSelectPinOe = r_reg.selOe;
   assign returnPinOut = PIN_LOW;
   assign returnPinOe = 1'b0;
   assign holdPinOut = r_reg.hold;
   assign holdPinOe = r_reg.holdOe;
   // open drain: only the enable moves
   assign pseudoGroundOut = PSEUDO_GROUND_OUT_LEVEL;
   assign pseudoGroundOe = r_reg.pgndOe;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   localparam int HALF_HI = HALF;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence parkStep;
      r_reg.state == ST_PARK;
   endsequence

   sequence allReleased;
      (r_reg.state == ST_IDLE) && !r_reg.clkOe && !r_reg.dataOe && !r_reg.selOe && !r_reg.holdOe;
   endsequence

   pseudo_ground_out_active_a: assert property (r_reg.state == ST_ACTIVE |-> r_reg.pgndOe)
      else $error("pseudo ground not pulled low during operation");
   pseudo_ground_out_idle_a: assert property (r_reg.state == ST_IDLE |-> !r_reg.pgndOe && !r_reg.clkOe)
      else $error("drivers active while idle");
   pins_release_a: assert property (parkStep |-> ##[1:HALF_HI] allReleased)
      else $error("pins not released after park");
   park_ones_a: assert property (parkStep |-> r_reg.clk && r_reg.data && r_reg.sel)
      else $error("park did not drive ones");
   spi_select_a: assert property (r_reg.state == ST_ACTIVE && r_reg.mode == MODE_SPI |-> !r_reg.sel)
      else $error("chip select high during flash access");
   wp_released_a: assert property (r_reg.mode != MODE_SCAN |-> !r_reg.holdOe)
      else $error("multi-use pin driven outside scan mode");
   hold_level_a: assert property ($rose(r_reg.holdOe) |-> r_reg.hold == !$past(haltVendor))
      else $error("hold level wrong for target family");
   mode_frozen_a: assert property (r_reg.state != ST_IDLE && $past(r_reg.state) != ST_IDLE |-> $stable(r_reg.mode))
      else $error("mode changed during operation");
   // the clock also drops when an operation opens after a parked-high finish; no sample belongs to that
   sample_at_fall_a: assert property ($fell(r_reg.clk) && $past(r_reg.state) == ST_ACTIVE |->
      r_reg.rxValid && r_reg.rxData == $past(r_reg.retSync))
      else $error("return data not sampled at falling edge");
   data_on_low_a: assert property (r_reg.state == ST_ACTIVE && $changed(r_reg.data) |-> !r_reg.clk)
      else $error("data-out changed while clock high");
   clock_half_a: assert property ($rose(r_reg.clk) && r_reg.state == ST_ACTIVE |-> ##HALF_HI $fell(r_reg.clk))
      else $error("clock high time wrong");

endmodule : mtsp_port

//--- rtl/mtsp_tick_div.sv
// divider that turns the system clock into a one-cycle tick every DIV cycles
// assumes clear is driven from logic on the same clock
module mtsp_tick_div #(
   parameter int unsigned DIV = 4
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clear,
   output logic tick
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

   typedef struct packed {
      logic [W-1:0] count;
      logic tick;
   } mtsp_div_t;

   mtsp_div_t divReg;
   mtsp_div_t divNext;

   // a divide by one could never give a low and a high phase
   if (DIV < 2) begin : gen_bad_div
      $error("mtsp_tick_div: DIV must be at least 2");
   end

   // count up, wrap and pulse; clear restarts the phase
   always_comb begin
      divNext = divReg;
      divNext.tick = 1'b0;
      if (clear) begin
         divNext.count = '0;
      end else if (divReg.count == W'(DIV - 1)) begin
         divNext.count = '0;
         divNext.tick = 1'b1;
      end else begin
         divNext.count = divReg.count + W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         divReg <= '0;
      end else begin
         divReg <= divNext;
      end
   end

   assign tick = divReg.tick;

endmodule : mtsp_tick_div

//--- tb/mtsp_port_test.sv
// self-checking bench of the multimode target serial port
// assumes the far-side model answers; idle pins read high through weak pull-ups
module mtsp_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   import mtsp_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   mtsp_mode_t modeSel = MODE_SCAN;
   logic haltEnable = 1'b0;
   logic haltVendor = 1'b0;
   logic opRequest = 1'b0;
   logic bitValid = 1'b0;
   logic bitData = 1'b0;
   logic bitSel = 1'b0;
   logic bitAck, rxValid, rxData, busy, clkOut, clkOe, datOut, datOe, selOut, selOe;
   logic retOut, retOe, holdOut, holdOe, pgOut, pgOe, retPin;
   logic [31:0] pattern = 32'h0;
   logic [31:0] seenData, seenSel;
   int nRise, nSlip;
   int nFail = 0;
   int checks = 0;
   int cycles = 0;
   logic rxQ[$];
   // pin levels with the target pull-ups
   wire logic clkLine = clkOe ? clkOut : 1'b1;
   wire logic datLine = datOe ? datOut : 1'b1;
   wire logic selLine = selOe ? selOut : 1'b1;
   wire logic holdLine = holdOe ? holdOut : 1'b1;
   mtsp_port #(.HALF(4)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .modeSel(modeSel),
      .haltEnable(haltEnable), .haltVendor(haltVendor), .opRequest(opRequest), .bitValid(bitValid),
      .bitData(bitData), .bitSel(bitSel), .bitAck(bitAck), .rxValid(rxValid), .rxData(rxData),
      .busy(busy), .sharedClockPinIn(clkLine), .sharedClockPinOut(clkOut), .sharedClockPinOe(clkOe),
      .dataPinIn(datLine), .dataPinOut(datOut), .dataPinOe(datOe), .sharedSelectPinIn(selLine),
      .sharedSelectPinOut(selOut), .sharedSelectPinOe(selOe), .returnPinIn(retPin),
      .returnPinOut(retOut), .returnPinOe(retOe), .holdPinIn(holdLine), .holdPinOut(holdOut),
      .holdPinOe(holdOe), .pseudoGroundOut(pgOut), .pseudoGroundOe(pgOe));
   mtsp_target_model tgt_u (.clk_sys(clk_sys), .sharedClock(clkLine), .clockOe(clkOe),
      .dataPin(datLine), .selectPin(selLine), .pgndOn(pgOe), .pattern(pattern), .returnPin(retPin),
      .nRise(nRise), .seenData(seenData), .seenSel(seenSel), .nSlip(nSlip));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         nFail++;
         conclude();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         nFail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   // one cycle of watching: returned bits and the pins of an active or parking operation
   task automatic step(input mtsp_mode_t m, input logic hEn, input logic hVen);
      @(negedge clk_sys);
      if (rxValid === 1'b1) rxQ.push_back(rxData);
      if (pgOe === 1'b1) begin
         check("pseudo_ground_out", pgOut, 1'b0);
         check("ret", {retOe, retOut}, 2'h0);
         check("dirs", {retOe, clkOe, datOe, selOe}, 4'h7);
         check("hold oe", holdOe, m == MODE_SCAN && hEn);
         if (holdOe === 1'b1) check("hold", holdOut, !hVen);
         if (m == MODE_SPI) check("cs", selOut, 1'b0);
      end else if (busy === 1'b1) begin
         check("park", {clkOut, datOut, selOut}, 3'h7);
      end
   endtask : step
   task automatic run_op(input mtsp_mode_t m, input int n, input logic [31:0] dat,
         input logic [31:0] sel, input logic hEn, input logic hVen);
      int w;
      logic [31:0] mask;
      mask = (32'h1 << n) - 32'h1;
      rxQ.delete();
      @(negedge clk_sys);
      modeSel = m;
      haltEnable = hEn;
      haltVendor = hVen;
      opRequest = 1'b1;
      for (int i = 0; i < n; i++) begin
         bitData = dat[i];
         bitSel = sel[i];
         bitValid = 1'b1;
         w = 0;
         do begin
            step(m, hEn, hVen);
            w++;
         end while (bitAck !== 1'b1 && w < 100);
         check("ack", bitAck, 1'b1);
      end
      bitValid = 1'b0;
      opRequest = 1'b0;
      w = 0;
      while (busy !== 1'b0 && w < 200) begin
         step(m, hEn, hVen);
         w++;
      end
      check("idle", busy, 1'b0);
      check("rx count", rxQ.size(), n);
      for (int i = 0; i < n; i++) check("rx bit", rxQ[i], pattern[i]);
      check("clocks", nRise, n);
      check("data", seenData & mask, dat & mask);
      check("select", seenSel & mask, (m == MODE_SPI ? 32'h0 : sel) & mask);
      check("stable", nSlip, 0);
      check("released", {clkOe, datOe, selOe, holdOe, pgOe}, 5'h0);
   endtask : run_op
   task automatic scan_case;
      pattern = 32'h96;
      for (int k = 0; k < 3; k++) run_op(MODE_SCAN, 8, 32'hA5, 32'h3C, k != 0, k == 1);
   endtask : scan_case
   task automatic spi_case;
      pattern = 32'h5A3;
      run_op(MODE_SPI, 12, 32'hC35, 32'hFFF, 1'b1, 1'b0);
   endtask : spi_case
   task automatic serial_case;
      pattern = 32'h1C7;
      run_op(MODE_SERIAL, 10, 32'h2D1, 32'h3FE, 1'b1, 1'b0);
   endtask : serial_case
   // the unused mode code must leave the port idle and the clock, data, select and pseudo ground pins released
   task automatic refused_case;
      @(negedge clk_sys);
      modeSel = mtsp_mode_t'(2'h3);
      opRequest = 1'b1;
      repeat (8) @(negedge clk_sys);
      check("refused", {busy, clkOe, datOe, selOe, pgOe}, 5'h0);
      opRequest = 1'b0;
   endtask : refused_case
   initial begin
      repeat (6) @(negedge clk_sys);
      reset_n = 1'b1;
      scan_case();
      spi_case();
      refused_case();
      serial_case();
      conclude();
   end
endmodule : mtsp_port_test

//--- tb/mtsp_target_model.sv
// far-side model: scan chain, serial flash or slave-serial targets on the shared pins
// assumes the pins are looked at on clk_sys; target clock edges are found from that
module mtsp_target_model (
   input wire logic clk_sys,
   input wire logic sharedClock,
   input wire logic clockOe,
   input wire logic dataPin,
   input wire logic selectPin,
   input wire logic pgndOn,
   input wire logic [31:0] pattern,
   output logic returnPin,
   output int nRise,
   output logic [31:0] seenData,
   output logic [31:0] seenSel,
   output int nSlip
);
   timeunit 1ns;
   timeprecision 100ps;
   logic prevClk = 1'b1;
   logic prevOe = 1'b0;
   logic prevData = 1'b1;
   logic prevSel = 1'b1;
   int idx = 0;
   initial begin
      returnPin = 1'b1;
      nRise = 0;
      nSlip = 0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // edge finder; a released return line must not keep showing the last bit
   always @(posedge clk_sys) begin
      if (clockOe && !prevOe) begin
         idx = 0;
         nRise <= 0;
         returnPin <= pattern[0];
      end else if (!clockOe && prevOe) begin
         returnPin <= ~returnPin;
      end else if (pgndOn && clockOe && !prevClk && sharedClock) begin
         // park lifts the clock with pseudo ground already off; that rise carries no bit
         seenData[nRise] <= dataPin;
         seenSel[nRise] <= selectPin;
         nRise <= nRise + 1;
      end else if (clockOe && prevClk && !sharedClock) begin
         idx = idx + 1;
         // every target answers alike: the next pattern bit goes out at each falling edge, in slave-serial mode too
         returnPin <= pattern[idx];
      end
      // targets sample at the rise, so nothing may move while the clock is high
      if (pgndOn && sharedClock && (dataPin !== prevData || selectPin !== prevSel)) begin
         nSlip <= nSlip + 1;
      end
      prevClk <= sharedClock;
      prevOe <= clockOe;
      prevData <= dataPin;
      prevSel <= selectPin;
   end
endmodule : mtsp_target_model
